// file: src/adc_host_ctrl.sv
// Purpose: host controller that drives the half-flash converter over its strobes
// Assumes: converter pins are synchronous to clk_sys; result bus is shared
// Notes: one request starts one read cycle; result of pipelined reads lags one
//
// Summary of operation
// - host uses only chip select and read strobe, both active low
// - read strobe length chooses wait-state or pipelined mode
// - host needs a further read to fetch a pipelined result
// - host spaces pipelined read cycles at least 2.5 us apart
// - conversions need 1 us plus 600 ns; no faster than 2.5 us
`timescale 1ns/1ps
`include "adc_host_defs.svh"
module adc_host_ctrl
  import adc_host_pkg::*;
#(
  parameter int CHAN_W = `CHAN_W,
  parameter int SPACING_CYC = `READ_SPACING_CYC,
  parameter int TIMEOUT_CYC = `CONV_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // user request side
  input wire logic reqValid,
  input wire logic reqMode,
  input wire logic [CHAN_W-1:0] reqChan,
  output logic reqReady,
  output logic rspValid,
  output logic [`DATA_W-1:0] rspData,
  output logic rspTimeout,
  // converter strobes and address
  output logic chipSel_n,
  output logic readStrobe_n,
  output logic [CHAN_W-1:0] chanSel,
  // converter status, ready is open drain as seen by the host
  input wire logic convReady,
  input wire logic convDone_n,
  // converter result bus
  input wire logic [`DATA_W-1:0] resultBus
);
  localparam logic [`COUNT_W-1:0] STROBE_LOAD = `COUNT_W'(`STROBE_LOW_CYC);
  localparam logic [`COUNT_W-1:0] SPACE_LOAD = `COUNT_W'(SPACING_CYC);

  host_state_e state_ff;
  logic mode_ff;
  logic timerLoad;
  logic [`COUNT_W-1:0] timerVal;
  logic timerDone;
  logic [`COUNT_W-1:0] wait_ff;
  logic doneArmed_ff;
  logic waitEnd;

  ////////////////////////////////////////////////////////////////////////////
  // shared timer: strobe width and read spacing
  cycle_timer #(.W(`COUNT_W)) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(timerLoad),
    .loadVal(timerVal),
    .done(timerDone)
  );

  // timer is reloaded on entry to the strobe and gap phases
  always_comb begin
    timerLoad = 1'b0;
    timerVal = STROBE_LOAD;
    if (state_ff == ST_SELECT) begin
      timerLoad = 1'b1;
    end else if (state_ff == ST_RELEASE) begin
      timerLoad = 1'b1;
      timerVal = SPACE_LOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_WAIT;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (reqValid) begin
            mode_ff <= reqMode;
            state_ff <= ST_SELECT;
          end
        end
        ST_SELECT: state_ff <= ST_STROBE; // address settles with select, a cycle before the read strobe
        ST_STROBE: begin
          if (mode_ff == MODE_PIPE && timerDone) begin
            state_ff <= ST_RELEASE; // short strobe
          end else if (mode_ff == MODE_WAIT) begin
            state_ff <= ST_WAITEND;
          end
        end
        ST_WAITEND: begin
          // hold read low until ready floats, done falls or the timeout runs out
          if (waitEnd || wait_ff == '0) begin
            state_ff <= ST_RELEASE;
          end
        end
        ST_RELEASE: state_ff <= ST_GAP;
        ST_GAP: begin
          if (timerDone) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // conversion timeout guard in wait-state mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_ff <= '0;
    end else if (state_ff == ST_STROBE) begin
      wait_ff <= `COUNT_W'(TIMEOUT_CYC);
    end else if (state_ff == ST_WAITEND && wait_ff != '0) begin
      wait_ff <= wait_ff - 1'b1;
    end
  end

  // a done flag still low from an earlier read must not end a new wait;
  // only a low that follows a high seen since the strobe counts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      doneArmed_ff <= 1'b0;
    end else if (state_ff == ST_STROBE) begin
      doneArmed_ff <= convDone_n;
    end else if (convDone_n) begin
      doneArmed_ff <= 1'b1;
    end
  end

  // ready floating is trusted at once, done low only once armed
  assign waitEnd = convReady || (doneArmed_ff && !convDone_n);

  ////////////////////////////////////////////////////////////////////////////
  // strobes and address, both active low, nothing else drives the converter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chipSel_n <= 1'b1;
      readStrobe_n <= 1'b1;
      chanSel <= '0;
    end else begin
      if (state_ff == ST_IDLE && reqValid) begin
        chanSel <= reqChan;
        chipSel_n <= 1'b0;
      end
      if (state_ff == ST_SELECT) begin
        readStrobe_n <= 1'b0;
      end
      if (state_ff == ST_RELEASE) begin
        chipSel_n <= 1'b1;
        readStrobe_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture: bus is valid only while both strobes low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rspValid <= 1'b0;
      rspData <= '0;
      rspTimeout <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      rspTimeout <= 1'b0;
      if (state_ff == ST_WAITEND && waitEnd) begin
        rspValid <= 1'b1;
        rspData <= resultBus;
      end else if (state_ff == ST_WAITEND && wait_ff == '0) begin
        rspTimeout <= 1'b1; // no end seen, give up rather than hang
      end else if (state_ff == ST_STROBE && mode_ff == MODE_PIPE && timerDone) begin
        rspValid <= 1'b1;
        rspData <= resultBus; // previous result
      end
    end
  end

  // ready to take a request only when idle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state_ff == ST_IDLE && !reqValid) || (state_ff == ST_GAP && timerDone);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_strobe_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !readStrobe_n |-> !chipSel_n) else $error("read low without select");
  chk_addr_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !chipSel_n |=> $stable(chanSel) || $rose(chipSel_n)) else $error("address moved");
  chk_read_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(chipSel_n) |-> chipSel_n [*8]) else $error("reads too close");
  chk_gap_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff == ST_GAP && !timerDone |=> chipSel_n) else $error("select in gap");
  chk_select_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(readStrobe_n) |-> $past(!chipSel_n)) else $error("select must lead");
  chk_pipe_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rspValid && mode_ff == MODE_PIPE |=> chipSel_n) else $error("pipe read not ended");
  chk_wait_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff == ST_WAITEND && doneArmed_ff && !convDone_n |=> rspValid)
    else $error("result missed");
  chk_ready_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff == ST_WAITEND && convReady |=> rspValid) else $error("ready end missed");
  chk_release_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff == ST_RELEASE |=> chipSel_n && readStrobe_n) else $error("strobes held");
endmodule

// file: src/adc_host_defs.svh
// Purpose: timing and width constants for the converter host controller
// Assumes: system clock of 125 MHz (8 ns period)
// Notes: times are kept in ns; cycle counts derive from them
`ifndef ADC_HOST_DEFS_SVH
`define ADC_HOST_DEFS_SVH

`define CLK_PERIOD_NS 8
// track phase before the upper nibble is latched
`define TRACK_TIME_NS 1000
// upper nibble latched to conversion end
`define LOWER_STAGE_NS 600
// least spacing between read cycles in pipelined mode
`define READ_SPACING_NS 2500
// worst-case conversion end wait before the host gives up
`define CONV_TIMEOUT_NS 4000
// least time in ns a strobe must stay low in pipelined mode (cycles round up)
`define STROBE_LOW_NS 200
`define CYC_CEIL(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_SPACING_CYC `CYC_CEIL(`READ_SPACING_NS)
`define STROBE_LOW_CYC `CYC_CEIL(`STROBE_LOW_NS)
`define CONV_TIMEOUT_CYC (`CONV_TIMEOUT_NS / `CLK_PERIOD_NS)
`define COUNT_W 12
`define DATA_W 8
`define CHAN_W 3

`endif

// file: src/adc_host_pkg.sv
// Purpose: types shared by the converter host controller
// Assumes: nothing beyond the defs header
// Notes: mode values select wait-state or pipelined reads
package adc_host_pkg;
  typedef enum logic {MODE_WAIT, MODE_PIPE} xfer_mode_e;
  typedef enum {ST_IDLE, ST_SELECT, ST_STROBE, ST_WAITEND, ST_RELEASE, ST_GAP} host_state_e;
endpackage

// file: src/cycle_timer.sv
// Purpose: down-counter used for strobe width and read spacing
// Assumes: load pulses are synchronous to clk_sys
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  // status
  output logic done
);
  logic [W-1:0] count_ff;

  // load takes priority over counting down
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= loadVal;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign done = (count_ff == '0);
endmodule

// file: verif/adc_dev_model.sv
// Purpose: behavioural converter on the far side of the host controller
// Assumes: pins sampled on clk_sys; the bench pulls the ready wire up
// Notes: result byte is {channel, conversion count}
`timescale 1ns/1ps
module adc_dev_model #(
  parameter int TRACK_CYC = 125,
  parameter int LOWER_CYC = 75
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host strobes
  input wire logic chipSel_n,
  input wire logic readStrobe_n,
  input wire logic [2:0] chanSel,
  // bench steering
  input wire logic pipeHint,
  input wire logic slowRun,
  // status and data
  output logic rdyOe,
  output logic convDone_n,
  output logic [7:0] resultBus
);
  logic cs_ff, rd_ff, busy_ff, sel, start, rise, fin;
  logic [2:0] chan_ff;
  logic [7:0] out_ff, cnt_ff;
  int tmr_ff, trk;
  ////////////////////////////////////////
  // strobe decode, both low selects
  assign sel = !chipSel_n && !readStrobe_n;
  assign start = sel && (cs_ff || rd_ff);
  assign rise = (chipSel_n && !cs_ff) || (readStrobe_n && !rd_ff);
  assign trk = slowRun ? TRACK_CYC * 5 : TRACK_CYC; // slow part overruns host wait
  assign fin = busy_ff && tmr_ff == trk + LOWER_CYC - 1;
  // floating bus shows the inverse, never a stale copy; floats while converting unless pipeHint is set
  assign resultBus = (sel && (pipeHint || (!busy_ff && !convDone_n))) ?
    out_ff : ~out_ff;
  // previous strobe levels
  always_ff @(posedge clk_sys) begin
    cs_ff <= rst_n ? chipSel_n : 1'b1;
    rd_ff <= rst_n ? readStrobe_n : 1'b1;
  end
  // conversion: track, upper nibble, lower nibble
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      out_ff <= 8'h00;
      cnt_ff <= 8'h00;
    end else if (start) begin
      busy_ff <= 1'b1;
      tmr_ff <= 0;
      chan_ff <= chanSel;
    end else if (busy_ff) begin
      tmr_ff <= tmr_ff + 1;
      if (tmr_ff == trk - 1) out_ff[7:4] <= {chan_ff, cnt_ff[4]};
      if (fin) begin
        out_ff[3:0] <= cnt_ff[3:0];
        busy_ff <= 1'b0;
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
  // done flag and open-drain ready
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      convDone_n <= 1'b1;
      rdyOe <= 1'b0;
    end else begin
      if (fin) convDone_n <= 1'b0;
      else if (rise) convDone_n <= 1'b1;
      if (!chipSel_n && cs_ff) rdyOe <= 1'b1;
      else if (fin || (chipSel_n && !cs_ff)) rdyOe <= 1'b0;
    end
  end
endmodule

// file: verif/tb.sv
// Purpose: self-checking bench for the converter host controller
// Assumes: converter model on the far side, ready pulled up here
// Notes: driver queues expected bytes, a monitor checks them in order
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst_n, reqValid, reqMode, reqReady, rspValid, rspTimeout;
  logic chipSel_n, readStrobe_n, convReady, convDone_n, rdyOe, pipeHint, slowRun;
  logic [2:0] reqChan, chanSel;
  logic [7:0] rspData, resultBus;
  logic [8:0] expQ[$], lastRes;
  int miscompares, checked, seed, cnt;
  ////////////////////////////////////////
  adc_host_ctrl #(.CHAN_W(3)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .reqValid(reqValid), .reqMode(reqMode), .reqChan(reqChan), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .rspTimeout(rspTimeout),
    .chipSel_n(chipSel_n), .readStrobe_n(readStrobe_n), .chanSel(chanSel),
    .convReady(convReady), .convDone_n(convDone_n), .resultBus(resultBus));
  adc_dev_model model_u (.clk_sys(clk_sys), .rst_n(rst_n), .chipSel_n(chipSel_n),
    .readStrobe_n(readStrobe_n), .chanSel(chanSel), .pipeHint(pipeHint),
    .slowRun(slowRun), .rdyOe(rdyOe), .convDone_n(convDone_n), .resultBus(resultBus));
  // pull-up on the ready wire
  assign convReady = rdyOe ? 1'b0 : 1'b1;
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one read: wait for acceptance, note the expectation, wait for the answer
  task automatic doRead(input logic mode, input logic slow, input logic [2:0] ch);
    int n;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqMode <= mode;
    reqChan <= ch;
    pipeHint <= mode;
    slowRun <= slow;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (reqReady !== 1'b1 && n < 1000);
    check({8'h00, reqReady}, 9'h001);
    reqValid <= 1'b0;
    if (slow) expQ.push_back(9'h100);
    else if (mode) expQ.push_back(lastRes);
    else expQ.push_back({1'b0, ch, cnt[4:0]});
    lastRes = {1'b0, ch, cnt[4:0]};
    cnt++;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rspValid !== 1'b1 && rspTimeout !== 1'b1 && n < 2000);
    check({8'h00, rspValid | rspTimeout}, 9'h001);
    // a timed-out conversion still finishes inside the converter
    while (slow && convDone_n !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (slow) check({8'h00, convDone_n}, 9'h000);
  endtask
  // answers compared in order against the queued notes
  always @(posedge clk_sys) begin
    if (rspValid === 1'b1 || rspTimeout === 1'b1) begin
      check({rspTimeout, rspValid ? rspData : 8'h00},
            expQ.size() > 0 ? expQ.pop_front() : 9'h1FF);
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // watchdog, far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    seed = 32'h17A37420;
    {rst_n, reqValid, reqMode, pipeHint, slowRun} = 5'h00;
    reqChan = 3'h0;
    lastRes = 9'h000;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // every channel code once in wait-state mode
    for (int i = 0; i < 8; i++) doRead(1'b0, 1'b0, 3'(i));
    // slow conversion overruns the wait, then the first pipelined read fetches it
    doRead(1'b0, 1'b1, 3'h5);
    for (int i = 0; i < 4; i++) doRead(1'b1, 1'b0, 3'($random(seed)));
    // back to wait-state while the last pipelined conversion left done low
    doRead(1'b0, 1'b0, 3'h6);
    // let the monitor take the last answer before the queue is inspected
    @(posedge clk_sys);
    check(9'(expQ.size()), 9'h000);
    stop_test();
  end
endmodule
